// file: verilog/fifo_pkg.sv
// Purpose: shared constants and carriers for the clocked flag fifo
// Assumes: one core clock drives both ports
// Notes: depth default is the largest documented array
package fifo_pkg;
	localparam int WORD_W = 18;
	localparam int DEPTH_DEF = 2048;
	localparam int ALMOST_DIST = 16;
	localparam int LOW_BYTE_LSB = 0;
	localparam int LOW_BYTE_MSB = 7;
	localparam int HIGH_BYTE_LSB = 9;
	localparam int HIGH_BYTE_MSB = 16;
	localparam logic [WORD_W-1:0] DATA_RESET = 18'h00000;
	localparam logic [1:0] BUF_ENTRIES = 2'h2;

	typedef logic [WORD_W-1:0] word_t;

	typedef struct packed {
		logic empty_full_n;
		logic almost_flag;
		logic half_full_flag;
	} flags_s;

	localparam flags_s FLAGS_RESET = '{empty_full_n: 1'b0, almost_flag: 1'b0, half_full_flag: 1'b1};

	typedef struct packed {
		word_t data;
		logic parity_low;
		logic parity_high;
	} rd_out_s;
endpackage : fifo_pkg

// file: verilog/clocked_fifo_flags_reset.sv
// Purpose: 18-bit fifo with enabled write/read ports, flags, parity, retransmit
// Assumes: both ports on core_clk; port inputs synchronous to it
// Notes: write side passes a two-entry buffer before the array
`timescale 1ns/1ps
module clocked_fifo_flags_reset import fifo_pkg::*; #(
	parameter int DEPTH = DEPTH_DEF
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic master_reset_n,
	input wire logic write_enable_n,
	input wire word_t write_data,
	output logic write_ready,
	input wire logic read_enable_n,
	input wire logic output_enable_n,
	input wire logic cascade_mode,
	input wire logic parity_gen_en,
	input wire logic retransmit_n,
	output word_t read_data,
	output logic read_data_oe_n,
	output logic parity_bit_low_byte,
	output logic parity_bit_high_byte,
	output logic empty_full_n,
	output logic almost_flag,
	output logic half_full_flag
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
	localparam logic [AW:0] HALF_C = (AW+1)'(DEPTH / 2);
	localparam logic [AW:0] ALMOST_C = (AW+1)'(ALMOST_DIST);

	initial begin
		if (DEPTH < 4 * ALMOST_DIST || (1 << AW) != DEPTH)
			$error("DEPTH must be a power of two of at least 64");
	end

	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
		logic [AW:0] written;
		flags_s flags;
		rd_out_s out;
		word_t buf0;
		word_t buf1;
		logic [1:0] buf_cnt;
	} state_s;

	logic rst_sync1_ff;
	logic rst_sync2_ff;
	state_s st_ff;
	state_s nxt_st;
	word_t mem [DEPTH];
	logic mem_we;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync1_ff <= 1'b0;
			rst_sync2_ff <= 1'b0;
		end else begin
			rst_sync1_ff <= 1'b1;
			rst_sync2_ff <= rst_sync1_ff;
		end
	end

	// buffer stalls the writer rather than dropping words
	assign write_ready = st_ff.buf_cnt != BUF_ENTRIES;
	// full flag from the last edge still blocks; the fresh read is counted one edge later
	assign mem_we = st_ff.buf_cnt != 2'h0 && retransmit_n && !(st_ff.count == DEPTH_C
		|| (!st_ff.flags.empty_full_n && st_ff.count == DEPTH_C - 1'b1));

	always_comb begin
		logic take_in;
		logic do_read;
		logic [AW:0] cnt;
		take_in = 1'b0;
		do_read = 1'b0;
		cnt = st_ff.count;
		nxt_st = st_ff;
		take_in = !write_enable_n && write_ready;
		// empty flag from previous edge blocks a read of a too-recent write
		do_read = !read_enable_n && st_ff.count != '0 && !(st_ff.count <= ALMOST_C
			&& !st_ff.flags.empty_full_n && st_ff.written != '0 && st_ff.count == 1)
			&& retransmit_n;
		if (mem_we) begin
			nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
			if (st_ff.written != DEPTH_C)
				nxt_st.written = st_ff.written + 1'b1;
		end
		if (do_read) begin
			nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
			nxt_st.out.data = mem[st_ff.rd_ptr];
			nxt_st.out.parity_low = parity_gen_en && ^mem[st_ff.rd_ptr][LOW_BYTE_MSB:LOW_BYTE_LSB];
			nxt_st.out.parity_high = parity_gen_en && ^mem[st_ff.rd_ptr][HIGH_BYTE_MSB:HIGH_BYTE_LSB];
		end
		// otherwise output keeps last valid read word
		cnt = st_ff.count + (AW+1)'(mem_we) - (AW+1)'(do_read);
		if (!retransmit_n) begin
			// rewind to first word; flags follow the new count one edge later
			nxt_st.rd_ptr = '0;
			cnt = st_ff.written;
		end
		nxt_st.count = cnt;
		// flags follow count as of the last edge, every edge but master reset, enabled or not
		nxt_st.flags.empty_full_n = st_ff.count != '0 && st_ff.count != DEPTH_C;
		nxt_st.flags.almost_flag = !(st_ff.count <= ALMOST_C || DEPTH_C - st_ff.count <= ALMOST_C);
		nxt_st.flags.half_full_flag = !(st_ff.count > HALF_C);
		// buffer shift: drain one to array, accept one from writer
		case ({take_in, mem_we})
			2'b10: begin
				if (st_ff.buf_cnt == 2'h0)
					nxt_st.buf0 = write_data;
				else
					nxt_st.buf1 = write_data;
				nxt_st.buf_cnt = st_ff.buf_cnt + 2'h1;
			end
			2'b01: begin
				nxt_st.buf0 = st_ff.buf1;
				nxt_st.buf_cnt = st_ff.buf_cnt - 2'h1;
			end
			2'b11: begin
				if (st_ff.buf_cnt == 2'h1)
					nxt_st.buf0 = write_data;
				else begin
					nxt_st.buf0 = st_ff.buf1;
					nxt_st.buf1 = write_data;
				end
			end
			default: begin
			end
		endcase
		if (!master_reset_n) begin
			// host keeps enables idle here, so nothing is lost
			nxt_st = '0;
			nxt_st.flags = FLAGS_RESET;
			nxt_st.out.data = DATA_RESET;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			st_ff <= '0;
			st_ff.flags <= FLAGS_RESET;
			st_ff.out.data <= DATA_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// array has no reset; contents are don't-care until written
	always_ff @(posedge core_clk) begin
		if (mem_we)
			mem[st_ff.wr_ptr] <= st_ff.buf0;
	end

	assign read_data = st_ff.out.data;
	assign read_data_oe_n = output_enable_n || (cascade_mode && read_enable_n);
	assign parity_bit_low_byte = st_ff.out.parity_low;
	assign parity_bit_high_byte = st_ff.out.parity_high;
	assign empty_full_n = st_ff.flags.empty_full_n;
	assign almost_flag = st_ff.flags.almost_flag;
	assign half_full_flag = st_ff.flags.half_full_flag;
endmodule : clocked_fifo_flags_reset

// file: testbench/fifo_asserts.sv
// Purpose: port checks for the flag fifo
// Assumes: one clock domain
// Notes: bound to the top module
`timescale 1ns/1ps
module fifo_asserts import fifo_pkg::*; (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic master_reset_n,
	input wire logic read_enable_n,
	input wire logic output_enable_n,
	input wire logic cascade_mode,
	input wire logic parity_gen_en,
	input wire word_t read_data,
	input wire logic read_data_oe_n,
	input wire logic parity_bit_low_byte,
	input wire logic parity_bit_high_byte,
	input wire logic empty_full_n,
	input wire logic almost_flag,
	input wire logic half_full_flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	property p_oe; read_data_oe_n == (output_enable_n | (cascade_mode & read_enable_n)); endproperty
	a_oe: assert property (p_oe) else $error("oe");
	property p_mr_data; !master_reset_n |=> read_data == '0; endproperty
	a_mr_data: assert property (p_mr_data) else $error("clear");
	property p_mr_flags; !master_reset_n |=> {empty_full_n, almost_flag, half_full_flag} == 3'h1; endproperty
	a_mr_flags: assert property (p_mr_flags) else $error("flags");
	property p_par_lo; parity_gen_en && $past(parity_gen_en) |-> parity_bit_low_byte == ^read_data[7:0]; endproperty
	a_par_lo: assert property (p_par_lo) else $error("par lo");
	property p_par_hi; parity_gen_en && $past(parity_gen_en) |-> parity_bit_high_byte == ^read_data[16:9]; endproperty
	a_par_hi: assert property (p_par_hi) else $error("par hi");
	property p_hold; read_enable_n && master_reset_n |=> $stable(read_data); endproperty
	a_hold: assert property (p_hold) else $error("idle");
	property p_empty; master_reset_n && !empty_full_n && half_full_flag |=> $stable(read_data); endproperty
	a_empty: assert property (p_empty) else $error("empty");
	property p_almost; !empty_full_n && half_full_flag |-> !almost_flag; endproperty
	a_almost: assert property (p_almost) else $error("almost");
endmodule : fifo_asserts
bind clocked_fifo_flags_reset fifo_asserts fifo_asserts_inst (.core_clk, .arst_n, .master_reset_n,
	.read_enable_n, .output_enable_n, .cascade_mode, .parity_gen_en, .read_data, .read_data_oe_n,
	.parity_bit_low_byte, .parity_bit_high_byte, .empty_full_n, .almost_flag, .half_full_flag);

// file: testbench/fifo_reader.sv
// Purpose: consumer on the read port
// Assumes: go changes off the edge
// Notes: go low stalls the consumer
`timescale 1ns/1ps
module fifo_reader (
	input wire logic go,
	input wire logic master_reset_n,
	output logic read_enable_n
);
	assign read_enable_n = ~(go & master_reset_n);
endmodule : fifo_reader

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the flag fifo
// Assumes: inputs move on falling edges
// Notes: depth cut to 512 to keep the fill short
`timescale 1ns/1ps
module tb_top import fifo_pkg::*;;
	localparam int D = 512;
	logic core_clk = '0, arst_n = '0, master_reset_n = '0, write_enable_n = '1, go = '0;
	logic output_enable_n = '0, cascade_mode = '0, parity_gen_en = '1, retransmit_n = '1;
	logic write_ready, read_enable_n, read_data_oe_n, parity_bit_low_byte, parity_bit_high_byte;
	logic empty_full_n, almost_flag, half_full_flag;
	word_t write_data = '0, read_data;
	int error_cnt = 0, check_count = 0, n = 0;
	word_t wv[4] = '{18'h000FF, 18'h00001, 18'h00200, 18'h3FFFF};
	logic [1:0] pv[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
	logic [3:0] ot[4] = '{4'h9, 4'h0, 4'h5, 4'h6};
	clocked_fifo_flags_reset #(.DEPTH(D)) clocked_fifo_flags_reset_inst (.core_clk, .arst_n, .master_reset_n,
		.write_enable_n, .write_data, .write_ready, .read_enable_n, .output_enable_n, .cascade_mode,
		.parity_gen_en, .retransmit_n, .read_data, .read_data_oe_n, .parity_bit_low_byte,
		.parity_bit_high_byte, .empty_full_n, .almost_flag, .half_full_flag);
	fifo_reader fifo_reader_inst (.go, .master_reset_n, .read_enable_n);
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %0t saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	initial forever #10 core_clk = ~core_clk;
	initial begin
		#400000;
		error_cnt++;
		conclude();
	end
	initial begin
		// writes stay idle through both resets
		repeat (3) @(negedge core_clk);
		arst_n = '1;
		repeat (3) @(negedge core_clk);
		master_reset_n = '1;
		@(negedge core_clk);
		check({empty_full_n, almost_flag, half_full_flag}, 3'h1);
		check(read_data, '0);
		foreach (wv[i]) begin
			write_enable_n = '0;
			write_data = wv[i];
			@(negedge core_clk);
		end
		write_enable_n = '1;
		repeat (4) @(negedge core_clk);
		go = '1;
		foreach (wv[i]) begin
			@(negedge core_clk);
			check(read_data, wv[i]);
			check({parity_bit_high_byte, parity_bit_low_byte}, pv[i]);
		end
		repeat (3) @(negedge core_clk);
		check(read_data, wv[3]);
		foreach (ot[k]) begin
			@(negedge core_clk);
			{output_enable_n, cascade_mode, go} = ot[k][3:1];
			#1 check(read_data_oe_n, ot[k][0]);
		end
		{output_enable_n, cascade_mode, go} = '0;
		// the write after refusal must not be stored
		repeat (D + 8) begin
			@(negedge core_clk);
			write_enable_n = '0;
			write_data = write_ready ? word_t'(n) : 18'h3FFFF;
			n += int'(write_ready);
		end
		write_enable_n = '1;
		repeat (4) @(negedge core_clk);
		check({empty_full_n, almost_flag, half_full_flag}, 3'h0);
		check(n, D + 2);
		go = '1;
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk);
			check(read_data, word_t'(i));
		end
		go = '0;
		repeat (3) @(negedge core_clk);
		check({empty_full_n, almost_flag, half_full_flag}, 3'h1);
		conclude();
	end
endmodule : tb_top
